// >>> bench/host_model.sv
`timescale 1ns/1ps
module host_model (
	input  wire       clk,
	input  wire       reset,
	input  wire       send_attention_pulse,
	input  wire [2:0] status_code,
	output reg        status_read
);
	integer hits [0:7];
	reg     active;
	integer k;
	initial begin
		status_read = 1'b0;
		active = 1'b0;
		for (k = 0; k < 8; k++) hits[k] = 0;
		forever begin
			@(negedge clk);
			if (!reset && send_attention_pulse === 1'b1) begin
				active = 1'b1;
				hits[status_code]++;
				repeat (2) @(negedge clk);
				status_read = 1'b1;
				repeat (4) @(negedge clk);
				status_read = 1'b0;
				active = 1'b0;
			end
		end
	end
endmodule // host_model

// >>> bench/test_uplink_tx_azimuth_and_irq.sv
`timescale 1ns/1ps
`include "uplink_regs.vh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module test_uplink_tx_azimuth_and_irq;
	localparam CM = 300, RM = 1200;
	reg clk = 0, reset = 1, chg = 0, refp = 0, az_rd = 0, ovf = 0, udf = 0;
	reg tx_ld = 0, lim_ld = 0, run = 0, par_seen, mod_seen;
	reg [3:0] itype = 4'h0;
	reg [19:0] ttime = 20'h0000A;
	reg [15:0] lim = 16'hFFFF;
	wire status_read, attn, clr_n, oe, modl, par, busy;
	wire [13:0] bus, drv;
	wire [2:0] code;
	integer err_total = 0, samples_checked = 0, i, n, q, s, s4, s5;
	integer dur [0:2];
	reg [3:0] types [0:2];
	uplink_tx_azimuth_and_irq #(.CHANGE_MISS_CYCLES(CM), .REF_MISS_CYCLES(RM)) uut (
		.clk(clk), .reset(reset), .azimuth_change_pulse(chg), .azimuth_reference_pulse(refp),
		.azimuth_read(az_rd), .status_read(status_read), .interrogation_type(itype),
		.tx_time(ttime), .tx_time_load(tx_ld), .range_limit(lim), .range_limit_load(lim_ld),
		.range_run(run), .input_overflow_request(ovf), .input_underflow_request(udf),
		.azimuth_bus_out(bus), .azimuth_bus_oe(oe), .driver_array(drv), .status_code(code),
		.send_attention_pulse(attn), .request_clear_n(clr_n), .modulation_line(modl),
		.parity_select(par), .tx_busy(busy));
	host_model host (.clk(clk), .reset(reset), .send_attention_pulse(attn),
		.status_code(code), .status_read(status_read));
	initial forever #50 clk = ~clk;
	task test_done;
		if (err_total == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task tick(input integer k); repeat (k) @(negedge clk); endtask
	task timed_out; begin err_total++; test_done; end endtask
	task chg_pulses(input integer k);
		repeat (k) begin chg = 1; tick(5); chg = 0; tick(5); end
	endtask
	task ref_pulse; begin refp = 1; tick(5); refp = 0; tick(5); end endtask
	// wait until the host has gone quiet
	task settle;
		begin
			n = 0; q = 0;
			while (q < 12 && n < 400) begin
				tick(1); n++; q = (host.active || attn) ? 0 : q + 1;
			end
			if (n >= 400) timed_out;
		end
	endtask
	task t_pair;
		begin
			s4 = host.hits[3];
			s = host.hits[2]; ovf = 1; udf = 1; tick(1); ovf = 0; udf = 0;
			`CHK("attn early", 1'b0, attn)
			tick(1);
			`CHK("attn", 1'b1, attn)
			`CHK("code first", 3'h2, code)
			settle;
			`CHK("overflow served", s + 1, host.hits[2])
			`CHK("underflow served", s4 + 1, host.hits[3])
			`CHK("code next", 3'h3, code)
		end
	endtask
	task t_az;
		begin
			ref_pulse; chg_pulses(5); tick(3);
			`CHK("drv", 14'h0005, drv)
			`CHK("bus", 14'h0005, bus)
			az_rd = 1; tick(6);
			`CHK("oe", 1'b1, oe)
			chg_pulses(1); tick(3);
			`CHK("drv next", 14'h0006, drv)
			`CHK("bus frozen", 14'h0005, bus)
			az_rd = 0; tick(6);
			`CHK("bus free", 14'h0006, bus)
			ref_pulse; tick(3);
			`CHK("drv zero", 14'h0000, drv)
		end
	endtask
	task t_tx;
		begin
			for (i = 0; i < 3; i++) begin
				itype = types[i]; lim_ld = 1; tx_ld = 1; tick(1); lim_ld = 0; tx_ld = 0;
				s = host.hits[0]; run = 1; n = 0; par_seen = 0;
				mod_seen = 0;
				while (busy !== 1'b1 && n < 60) begin tick(1); n++; end
				if (n >= 60) timed_out;
				dur[i] = 0;
				while (busy === 1'b1 && dur[i] < 100) begin
					mod_seen = mod_seen | (modl === 1'b1);
					par_seen = par_seen | (par === 1'b1); tick(1); dur[i]++;
				end
				if (dur[i] >= 100) timed_out;
				run = 0; settle;
				`CHK("tx done served", s + 1, host.hits[0])
				`CHK("parity line", itype[3], par_seen)
				`CHK("mod line", 1'b1, mod_seen)
				`CHK("mod idle", 1'b0, modl)
			end
			`CHK("short len", 17, dur[1] - dur[0])
			`CHK("long len", 21, dur[2] - dur[1])
		end
	endtask
	task t_range;
		begin
			s = host.hits[1]; lim = 16'h0002; lim_ld = 1; tick(1); lim_ld = 0;
			run = 1; tick(50); run = 0; settle;
			`CHK("range start", s + 1, host.hits[1])
		end
	endtask
	task t_miss;
		begin
			ref_pulse; chg_pulses(1); settle; s4 = host.hits[4]; s5 = host.hits[5];
			tick(CM); settle;
			`CHK("change miss", s4 + 1, host.hits[4])
			`CHK("ref early", s5, host.hits[5])
			tick(RM); settle;
			`CHK("ref miss", s5 + 1, host.hits[5])
			`CHK("change once", s4 + 1, host.hits[4])
		end
	endtask
	initial begin
		types[0] = 4'h0; types[1] = 4'h8; types[2] = 4'hC;
		repeat (16) @(posedge clk);
		@(negedge clk) reset = 0;
		tick(2);
		t_pair; t_az; t_tx; t_range; t_miss;
		test_done;
	end
endmodule // test_uplink_tx_azimuth_and_irq

// >>> bench/uplink_checker_assertions.sv
`timescale 1ns/1ps
`include "uplink_regs.vh"
module uplink_checker (
	input wire               clk,
	input wire               reset,
	input wire               status_read,
	input wire [`AZ_W-1:0]   azimuth_bus_out,
	input wire               azimuth_bus_oe,
	input wire [`AZ_W-1:0]   driver_array,
	input wire [`CODE_W-1:0] status_code,
	input wire               send_attention_pulse,
	input wire               request_clear_n,
	input wire               tx_busy
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	property p_attn_one; send_attention_pulse |=> !send_attention_pulse; endproperty
	a_attn_one: assert property (p_attn_one) else $error("attention pulse too long");
	property p_clr_one; !request_clear_n |=> request_clear_n; endproperty
	a_clr_one: assert property (p_clr_one) else $error("clear pulse too long");
	property p_code_hold; !send_attention_pulse |-> $stable(status_code); endproperty
	a_code_hold: assert property (p_code_hold) else $error("code moved without attention");
	property p_code_range; send_attention_pulse |-> status_code <= 3'h5; endproperty
	a_code_range: assert property (p_code_range) else $error("status code unused value");
	property p_clr_gap; !request_clear_n |-> !send_attention_pulse ##1 !send_attention_pulse;
	endproperty
	a_clr_gap: assert property (p_clr_gap) else $error("attention too soon after clear");
	property p_clr_read; $fell(request_clear_n) |-> !status_read; endproperty
	a_clr_read: assert property (p_clr_read) else $error("clear while read active");
	property p_bus_hold; azimuth_bus_oe && $past(azimuth_bus_oe) |-> $stable(azimuth_bus_out);
	endproperty
	a_bus_hold: assert property (p_bus_hold) else $error("bus moved during read");
	property p_drv_step;
		$changed(driver_array) |-> driver_array == 14'h0000
			|| driver_array == $past(driver_array) + 14'h0001;
	endproperty
	a_drv_step: assert property (p_drv_step) else $error("azimuth jumped");
	property p_busy_len; $rose(tx_busy) |-> ##[1:80] !tx_busy; endproperty
	a_busy_len: assert property (p_busy_len) else $error("sequence never ended");
	c_attn: cover property (send_attention_pulse && status_code == 3'h1);
	c_clear: cover property (!request_clear_n);
	c_busy: cover property ($fell(tx_busy));
endmodule // uplink_checker
bind uplink_tx_azimuth_and_irq uplink_checker u_chk (
	.clk(clk), .reset(reset), .status_read(status_read),
	.azimuth_bus_out(azimuth_bus_out), .azimuth_bus_oe(azimuth_bus_oe),
	.driver_array(driver_array), .status_code(status_code),
	.send_attention_pulse(send_attention_pulse), .request_clear_n(request_clear_n),
	.tx_busy(tx_busy));

// >>> rtl/pin_sync.v
`timescale 1ns/1ps
`include "uplink_regs.vh"

module pin_sync (
	input  wire clk,
	input  wire reset,
	input  wire pin_in,
	output reg  level,
	output reg  rise,
	output reg  fall
);

	reg s1_r;
	reg s2_r;
	reg s3_r;

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			s1_r  <= 1'b0;
			s2_r  <= 1'b0;
			s3_r  <= 1'b0;
			level <= 1'b0;
			rise  <= 1'b0;
			fall  <= 1'b0;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			rise <= s2_r & s3_r & ~level;
			fall <= ~s2_r & ~s3_r & level;
			if (s2_r == s3_r) begin
				level <= s2_r;
			end
		end
	end

endmodule // pin_sync

// >>> rtl/tx_sequencer.v
`timescale 1ns/1ps
`include "uplink_regs.vh"

module tx_sequencer (
	input  wire                 clk,
	input  wire                 reset,
	input  wire                 start,
	input  wire [`TYPE_W-1:0]   type_in,
	output reg                  mod_line,
	output reg                  parity_sel,
	output reg                  done,
	output reg                  busy
);

	reg  [`SEQ_AW-1:0] addr_r;
	reg  [`TYPE_W-1:0] type_r;
	wire [7:0]         atcrbs_word;
	wire [7:0]         modes_word;
	wire [4:0]         ctrl_word;
	wire               end_sel;
	wire               par_sel;

	// modulation rom for ATCRBS types, one line per type
	function [7:0] rom_atcrbs;
		input [`SEQ_AW-1:0] a;
		begin
			case (a[5:1])
				5'h00: rom_atcrbs = 8'hFF;
				5'h02: rom_atcrbs = 8'h01;
				5'h04: rom_atcrbs = 8'h02;
				5'h05: rom_atcrbs = 8'h04;
				5'h06: rom_atcrbs = 8'h08;
				5'h08: rom_atcrbs = 8'h10;
				5'h09: rom_atcrbs = 8'h20;
				5'h0A: rom_atcrbs = 8'h40;
				5'h0B: rom_atcrbs = 8'h80;
				default: rom_atcrbs = 8'h00;
			endcase
		end
	endfunction

	// modulation rom for selective types, line 0 short, others long
	function [7:0] rom_modes;
		input [`SEQ_AW-1:0] a;
		begin
			if (a <= 6'h03 || (a >= 6'h08 && a <= 6'h0B))
				rom_modes = 8'hFF;
			else if (a >= `SEQ_PAR_START && a < `SEQ_END_SHORT)
				rom_modes = 8'hFF;
			else if (a >= `SEQ_PAR_START && a < `SEQ_END_LONG)
				rom_modes = 8'hFE;
			else
				rom_modes = 8'h00;
		end
	endfunction

	// control rom: end long, end short, end atcrbs, parity long, parity short
	function [4:0] rom_ctrl;
		input [`SEQ_AW-1:0] a;
		begin
			rom_ctrl = {a == `SEQ_END_LONG, a == `SEQ_END_SHORT, a == `SEQ_END_ATCRBS,
				a >= `SEQ_PAR_START && a < `SEQ_END_LONG,
				a >= `SEQ_PAR_START && a < `SEQ_END_SHORT};
		end
	endfunction

	assign atcrbs_word = rom_atcrbs(addr_r);
	assign modes_word  = rom_modes(addr_r);
	assign ctrl_word   = rom_ctrl(addr_r);

	assign end_sel = ~type_r[`TYPE_MODES_BIT] ? ctrl_word[2] :
		(type_r[`TYPE_LONG_BIT] ? ctrl_word[4] : ctrl_word[3]);
	assign par_sel = type_r[`TYPE_MODES_BIT] &
		(type_r[`TYPE_LONG_BIT] ? ctrl_word[1] : ctrl_word[0]);

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			addr_r     <= {`SEQ_AW{1'b0}};
			type_r     <= {`TYPE_W{1'b0}};
			mod_line   <= 1'b0;
			parity_sel <= 1'b0;
			done       <= 1'b0;
			busy       <= 1'b0;
		end else begin
			done <= 1'b0;
			if (!busy) begin
				mod_line   <= 1'b0;
				parity_sel <= 1'b0;
				if (start) begin
					type_r <= type_in;
					addr_r <= {`SEQ_AW{1'b0}};
					busy   <= 1'b1;
				end
			end else begin
				mod_line   <= type_r[`TYPE_MODES_BIT] ? modes_word[type_r[2:0]] :
					atcrbs_word[type_r[2:0]];
				parity_sel <= par_sel;
				addr_r     <= addr_r + 6'h01;
				if (end_sel) begin
					done <= 1'b1;
					busy <= 1'b0;
				end
			end
		end
	end

endmodule // tx_sequencer

// >>> rtl/uplink_regs.vh
`ifndef UPLINK_REGS_VH
`define UPLINK_REGS_VH

// clock and timing
`define CLK_MHZ             10
`define CHANGE_MISS_US      1000
`define REF_MISS_US         6000000
`define CHANGE_MISS_CYCLES  (`CHANGE_MISS_US * `CLK_MHZ)
`define REF_MISS_CYCLES     (`REF_MISS_US * `CLK_MHZ)

// widths
`define AZ_W                14
`define RANGE_W             20
`define LIMIT_W             16
`define TYPE_W              4
`define CODE_W              3
`define NUM_REQ             6
`define SEQ_AW              6
`define SYNC_N              4

// interrogation type field positions
`define TYPE_MODES_BIT      3
`define TYPE_LONG_BIT       2

// request flag index, equal to its status code
`define REQ_TX_DONE         0
`define REQ_RANGE_START     1
`define REQ_OVERFLOW        2
`define REQ_UNDERFLOW       3
`define REQ_CHANGE_MISS     4
`define REQ_REF_MISS        5

// sequence controller addresses
`define SEQ_END_ATCRBS      6'h18
`define SEQ_END_SHORT       6'h29
`define SEQ_END_LONG        6'h3E
`define SEQ_PAR_START       6'h0E

`endif

// >>> rtl/uplink_tx_azimuth_and_irq.v
// Operation
// - edge detect pulses to one clock
// - change pulses count 14-bit azimuth
// - holding register drives tristate bus
// - azimuth forwarded to driver array
// - address counter steps three roms
// - latch type at sequence start
// - type selects end and parity lines
// - six sources, 3-bit status code
// - fixed code per source
// - sticky request flag per source
// - priority encoder, transmit done first
// - one-shot loads code, sends attention
// - enable then latch and interrupt
// - decoder selects flag to clear
// - read end clears flag, one-shot
// - next pending code raises interrupt
// - range limit match restarts counter
// - transmit time match starts sequencer
`timescale 1ns/1ps
`include "uplink_regs.vh"

module uplink_tx_azimuth_and_irq #(
	parameter [31:0] CHANGE_MISS_CYCLES = `CHANGE_MISS_CYCLES,
	parameter [31:0] REF_MISS_CYCLES    = `REF_MISS_CYCLES
) (
	input  wire                 clk,
	input  wire                 reset,
	input  wire                 azimuth_change_pulse,
	input  wire                 azimuth_reference_pulse,
	input  wire                 azimuth_read,
	input  wire                 status_read,
	input  wire [`TYPE_W-1:0]   interrogation_type,
	input  wire [`RANGE_W-1:0]  tx_time,
	input  wire                 tx_time_load,
	input  wire [`LIMIT_W-1:0]  range_limit,
	input  wire                 range_limit_load,
	input  wire                 range_run,
	input  wire                 input_overflow_request,
	input  wire                 input_underflow_request,
	output reg  [`AZ_W-1:0]     azimuth_bus_out,
	output reg                  azimuth_bus_oe,
	output reg  [`AZ_W-1:0]     driver_array,
	output reg  [`CODE_W-1:0]   status_code,
	output reg                  send_attention_pulse,
	output reg                  request_clear_n,
	output wire                 modulation_line,
	output wire                 parity_select,
	output wire                 tx_busy
);

	localparam SYNC_CHANGE = 0;
	localparam SYNC_REF    = 1;
	localparam SYNC_AZREAD = 2;
	localparam SYNC_STREAD = 3;

	wire [`SYNC_N-1:0]  sync_in;
	wire [`SYNC_N-1:0]  sync_level;
	wire [`SYNC_N-1:0]  sync_rise;
	wire [`SYNC_N-1:0]  sync_fall;

	reg  [`AZ_W-1:0]    azimuth_counter;
	reg  [`RANGE_W-1:0] range_cnt_r;
	reg  [`LIMIT_W-1:0] range_limit_r;
	reg  [`RANGE_W-1:0] tx_time_r;
	reg                 tx_armed_r;
	reg                 range_period_start_request;
	reg                 tx_time_match;
	reg  [31:0]         change_wait_r;
	reg  [31:0]         ref_wait_r;
	reg                 missing_change_pulse_request;
	reg                 missing_reference_pulse_request;
	reg  [`NUM_REQ-1:0] flags_r;
	reg  [`NUM_REQ-1:0] flags_nxt;
	reg                 oneshot_r;
	integer             fi;

	wire                tx_done_request;
	wire                range_match;
	wire                time_match;
	wire [`NUM_REQ-1:0] req_vec;
	wire [`NUM_REQ-1:0] clear_vec;
	wire [`CODE_W-1:0]  enc_code;
	wire                any_pending;
	wire                fire;
	wire                clear_en;
	wire [7:0]          dec_vec;

	assign sync_in[SYNC_CHANGE] = azimuth_change_pulse;
	assign sync_in[SYNC_REF]    = azimuth_reference_pulse;
	assign sync_in[SYNC_AZREAD] = azimuth_read;
	assign sync_in[SYNC_STREAD] = status_read;

	genvar gi;
	generate
		for (gi = 0; gi < `SYNC_N; gi = gi + 1) begin : g_sync
			pin_sync u_sync (
				.clk    (clk),
				.reset  (reset),
				.pin_in (sync_in[gi]),
				.level  (sync_level[gi]),
				.rise   (sync_rise[gi]),
				.fall   (sync_fall[gi])
			);
		end
	endgenerate

	// unused encoder inputs sit inactive, lowest index has priority
	function [`CODE_W-1:0] prio_enc;
		input [7:0] pend;
		integer k;
		begin
			prio_enc = 3'h0;
			for (k = 7; k >= 0; k = k - 1) begin
				if (pend[k])
					prio_enc = k[2:0];
			end
		end
	endfunction

	function [7:0] dec3to8;
		input [`CODE_W-1:0] c;
		begin
			dec3to8 = 8'h01 << c;
		end
	endfunction

	// ---------------- azimuth decoder ----------------

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			azimuth_counter <= {`AZ_W{1'b0}};
			azimuth_bus_out <= {`AZ_W{1'b0}};
			azimuth_bus_oe  <= 1'b0;
			driver_array    <= {`AZ_W{1'b0}};
		end else begin
			if (sync_rise[SYNC_REF])
				azimuth_counter <= {`AZ_W{1'b0}};
			else if (sync_rise[SYNC_CHANGE])
				azimuth_counter <= azimuth_counter + 14'h0001;
			if (!sync_level[SYNC_AZREAD])
				azimuth_bus_out <= azimuth_counter;
			azimuth_bus_oe <= sync_level[SYNC_AZREAD];
			driver_array <= azimuth_counter;
		end
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			change_wait_r                <= 32'h00000000;
			missing_change_pulse_request <= 1'b0;
		end else begin
			missing_change_pulse_request <= 1'b0;
			// count rests at the limit, so one request per gap
			if (sync_rise[SYNC_CHANGE])
				change_wait_r <= 32'h00000000;
			else if (change_wait_r != CHANGE_MISS_CYCLES)
				change_wait_r <= change_wait_r + 32'h00000001;
			if (!sync_rise[SYNC_CHANGE] && change_wait_r == CHANGE_MISS_CYCLES - 32'h00000001)
				missing_change_pulse_request <= 1'b1;
		end
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			ref_wait_r                      <= 32'h00000000;
			missing_reference_pulse_request <= 1'b0;
		end else begin
			missing_reference_pulse_request <= 1'b0;
			if (sync_rise[SYNC_REF])
				ref_wait_r <= 32'h00000000;
			else if (ref_wait_r != REF_MISS_CYCLES)
				ref_wait_r <= ref_wait_r + 32'h00000001;
			if (!sync_rise[SYNC_REF] && ref_wait_r == REF_MISS_CYCLES - 32'h00000001)
				missing_reference_pulse_request <= 1'b1;
		end
	end

	// ---------------- transmission timing ----------------

	assign range_match = range_run &&
		(range_cnt_r[`RANGE_W-1:`RANGE_W-`LIMIT_W] == range_limit_r);
	assign time_match  = range_run && tx_armed_r &&
		(range_cnt_r == tx_time_r);

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			range_cnt_r                <= {`RANGE_W{1'b0}};
			range_limit_r              <= {`LIMIT_W{1'b0}};
			range_period_start_request <= 1'b0;
		end else begin
			if (range_limit_load)
				range_limit_r <= range_limit;
			if (!range_run || range_match)
				range_cnt_r <= {`RANGE_W{1'b0}};
			else
				range_cnt_r <= range_cnt_r + 20'h00001;
			range_period_start_request <= range_match;
		end
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			tx_time_r     <= {`RANGE_W{1'b0}};
			tx_armed_r    <= 1'b0;
			tx_time_match <= 1'b0;
		end else begin
			tx_time_match <= time_match;
			// one load arms one transmission
			if (tx_time_load) begin
				tx_time_r  <= tx_time;
				tx_armed_r <= 1'b1;
			end else if (time_match) begin
				tx_armed_r <= 1'b0;
			end
		end
	end

	tx_sequencer u_seq (
		.clk        (clk),
		.reset      (reset),
		.start      (tx_time_match),
		.type_in    (interrogation_type),
		.mod_line   (modulation_line),
		.parity_sel (parity_select),
		.done       (tx_done_request),
		.busy       (tx_busy)
	);

	// ---------------- interrupt generation ----------------

	assign req_vec[`REQ_TX_DONE]     = tx_done_request;
	assign req_vec[`REQ_RANGE_START] = range_period_start_request;
	assign req_vec[`REQ_OVERFLOW]    = input_overflow_request;
	assign req_vec[`REQ_UNDERFLOW]   = input_underflow_request;
	assign req_vec[`REQ_CHANGE_MISS] = missing_change_pulse_request;
	assign req_vec[`REQ_REF_MISS]    = missing_reference_pulse_request;

	assign enc_code    = prio_enc({2'b00, flags_r});
	assign any_pending = |flags_r;
	assign fire        = any_pending & ~oneshot_r;
	assign clear_en    = ~request_clear_n & oneshot_r;
	assign dec_vec     = dec3to8(status_code);
	assign clear_vec   = dec_vec[`NUM_REQ-1:0] & {`NUM_REQ{clear_en}};

	always @* begin
		flags_nxt = flags_r;
		for (fi = 0; fi < `NUM_REQ; fi = fi + 1) begin
			if (clear_vec[fi])
				flags_nxt[fi] = 1'b0;
			if (req_vec[fi])
				flags_nxt[fi] = 1'b1;
		end
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			flags_r <= {`NUM_REQ{1'b0}};
		end else begin
			flags_r <= flags_nxt;
		end
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			status_code <= {`CODE_W{1'b0}};
			oneshot_r   <= 1'b0;
		end else begin
			if (fire)
				status_code <= enc_code;
			if (clear_en)
				oneshot_r <= 1'b0;
			else if (fire)
				oneshot_r <= 1'b1;
		end
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			send_attention_pulse <= 1'b0;
			request_clear_n      <= 1'b1;
		end else begin
			send_attention_pulse <= fire;
			request_clear_n <= ~(sync_fall[SYNC_STREAD] & oneshot_r);
		end
	end

endmodule // uplink_tx_azimuth_and_irq
